// ==== dv/pti_bus_if_tb_top.sv ====
// self-checking bench for the host bus interface
`timescale 1ns/1ps
module pti_bus_if_tb_top;
  localparam logic [3:0] RD = pti_pkg::CMD_IO_RD;
  localparam logic [3:0] WR = pti_pkg::CMD_IO_WR;
  logic sys_clk = 0, rst = 1, quiet = 0, mreq_valid = 0, wdata_valid = 0;
  logic [31:0] h_ad = 32'h0, wdata = 32'h0, rd, v, ad_o, ad_w, m_ad, wlast, rdata;
  logic [3:0] h_cbe = 4'hF, cbe_o, cbe_w;
  logic [7:0] irq_src = 8'h00, wcnt;
  pti_pkg::pti_ctl_t hc = '1, mc, ctl_o, ctl_oe_n, ctl_w;
  pti_pkg::pti_mreq_t mreq = '0;
  logic ad_oe_n, cbe_oe_n, bus_request_n, bus_grant_n, int_oe_n, mreq_ready, mdone, mabort, rdata_valid, wdata_ready;
  int error_cnt = 0, checks = 0, cyc = 0, n, k;
  always #2 sys_clk = ~sys_clk;
  // control lines have pull-ups; released address lines carry a pattern
  assign ctl_w = (ctl_oe_n | ctl_o) & hc & mc;
  assign ad_w = !ad_oe_n ? ad_o : (!mc.trdy ? m_ad : h_ad);
  assign cbe_w = !cbe_oe_n ? cbe_o : h_cbe;
  pti_bus_if DUT (.sys_clk, .rst, .ad_i(ad_w), .ad_o, .ad_oe_n, .cbe_i(cbe_w), .cbe_o, .cbe_oe_n, .ctl_i(ctl_w),
    .ctl_o, .ctl_oe_n, .bus_request_n, .bus_grant_n, .wide_request_n(1'b0), .interrupt_pin_o(),
    .interrupt_pin_oe_n(int_oe_n), .io_base_range(24'h000012), .mem_base_range(24'hF00000), .irq_src,
    .tbi_mode_pin(1'b0), .mreq_valid, .mreq, .mreq_ready, .mdone, .mabort, .rdata, .rdata_valid, .wdata_valid,
    .wdata, .wdata_ready);
  pti_host_model HOST (.sys_clk, .rst, .quiet, .bus_request_n, .dev_frame_n(ctl_oe_n.frame | ctl_o.frame),
    .ctl_w, .ad_w, .bus_grant_n, .mc, .m_ad, .wcnt, .wlast);
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic acc(logic [3:0] cmd, logic [31:0] a, logic [31:0] d, logic bst, int dv);
    hc.frame = 0;
    h_ad = a;
    h_cbe = cmd;
    @(negedge sys_clk);
    hc.frame = !bst;
    hc.irdy = 0;
    h_cbe = 4'h0;
    h_ad = cmd[0] ? d : ~a;
    for (n = 1; n < 9 && ctl_w.devsel; n++) @(negedge sys_clk);
    chk("devsel delay", dv, n);
    if (dv == 2) begin
      for (n = 0; n < 9 && ctl_w.trdy; n++) @(negedge sys_clk);
      chk("trdy delay", cmd[0] ? 3 : 2, n);
      rd = ad_w;
      if (bst) chk("stop", 0, ctl_w.stop);
    end
    @(negedge sys_clk);
    hc = '1;
    h_cbe = 4'hF;
    h_ad = 32'h5A5A_A5A5;
    repeat (3) @(negedge sys_clk);
  endtask
  task automatic mwait;
    for (n = 0; n < 80 && !mdone && !mabort; n++) @(negedge sys_clk);
  endtask
  // valid stands until an edge that sees ready
  task automatic mgo;
    mreq_valid = 1;
    for (n = 0; n < 9 && !mreq_ready; n++) @(negedge sys_clk);
    @(negedge sys_clk);
    mreq_valid = 0;
  endtask
  task automatic mrd(logic [4:0] len);
    mreq.wr = 0;
    mreq.len = len;
    mgo;
    k = 0;
    for (n = 0; n < 80 && !mdone && !mabort; n++) begin
      @(negedge sys_clk);
      if (rdata_valid) begin
        v = rdata;
        k++;
      end
    end
  endtask
  task automatic test_done;
    if (error_cnt == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      test_done;
    end
  end
  initial begin
    repeat (5) @(negedge sys_clk);
    rst = 0;
    @(negedge sys_clk);
    acc(RD, 32'h125C, 0, 0, 2);
    chk("lat reset", 32'h0000_0100, rd);
    acc(pti_pkg::CMD_MEM_WR, 32'hF000_005C, 32'h0000_0133, 1, 2);
    acc(pti_pkg::CMD_MEM_RD, 32'hF000_005C, 0, 1, 2);
    chk("lat write", 32'h0000_0133, rd);
    acc(4'hA, 32'h125C, 0, 0, 9);
    acc(pti_pkg::CMD_MEM_RD, 32'h125C, 0, 0, 9);
    acc(WR, 32'h135C, 32'h1, 0, 9);
    acc(WR, 32'h1250, 32'h0000_00C0, 0, 2);
    acc(WR, 32'h1250, 32'h00FF_00C0, 0, 2);
    acc(RD, 32'h1250, 0, 0, 2);
    chk("cfg unlocked", 32'h00F3_00C0, rd);
    acc(WR, 32'h1254, 32'h00FF_FFFF, 0, 2);
    acc(WR, 32'h1250, 0, 0, 2);
    acc(WR, 32'h1254, 0, 0, 2);
    acc(RD, 32'h1254, 0, 0, 2);
    chk("cfg locked", 32'h0003_9430, rd);
    acc(WR, 32'h123C, 32'h0000_8001, 0, 2);
    irq_src = 8'h01;
    @(negedge sys_clk);
    irq_src = 8'h00;
    repeat (2) @(negedge sys_clk);
    chk("irq pin", 0, int_oe_n);
    acc(WR, 32'h123C, 32'h0000_0001, 0, 2);
    chk("irq gated", 1, int_oe_n);
    acc(WR, 32'h123C, 32'h0001_0001, 0, 2);
    acc(RD, 32'h123C, 0, 0, 2);
    chk("status clear", 32'h0000_0001, rd);
    wdata_valid = 1;
    for (n = 0; n < 20 && wdata_ready; n++) begin
      wdata = n;
      @(negedge sys_clk);
    end
    wdata_valid = 0;
    chk("fifo fill", 16, n);
    mreq = '{wr: 1'b1, addr: 64'h8000_0000, len: 5'd16};
    mgo;
    mwait;
    chk("write words", 16, wcnt);
    chk("write last", 32'hF, wlast);
    mrd(5'd2);
    chk("read last", 32'hA000_0011, v);
    chk("read words", 2, k);
    quiet = 1;
    mrd(5'd1);
    chk("abort", 1, mabort);
    repeat (4) @(negedge sys_clk);
    acc(RD, 32'h123C, 0, 0, 2);
    chk("abort status", 1, rd[24]);
    quiet = 0;
    acc(WR, 32'h125C, 32'h2, 0, 2);
    mrd(5'd16);
    chk("latency words", 3, k);
    acc(WR, 32'h12E0, 32'h0000_0200, 0, 2);
    acc(RD, 32'h125C, 0, 0, 2);
    chk("big endian", 32'h0201_0000, rd);
    test_done;
  end
endmodule

// ==== dv/pti_host_model.sv ====
// host bridge, arbiter and memory model answering master bursts
`timescale 1ns/1ps
module pti_host_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic quiet,
  input wire logic bus_request_n,
  input wire logic dev_frame_n,
  input wire pti_pkg::pti_ctl_t ctl_w,
  input wire logic [31:0] ad_w,
  output logic bus_grant_n,
  output pti_pkg::pti_ctl_t mc,
  output logic [31:0] m_ad,
  output logic [7:0] wcnt,
  output logic [31:0] wlast
);
  logic act;
  // zero-wait target: claims on the cycle after the address
  assign mc = act ? 5'b11001 : 5'b11111;
  always @(posedge sys_clk) begin
    bus_grant_n <= rst | bus_request_n;
    if (rst) begin
      act <= 1'b0;
      wcnt <= 8'h00;
      m_ad <= 32'hA000_0000;
    end else begin
      if (!dev_frame_n && !quiet) act <= 1'b1;
      // lets go as the last data phase completes, frame already high
      else if (ctl_w.frame) act <= 1'b0;
      if (act && !ctl_w.irdy) begin
        wcnt <= wcnt + 8'h01;
        wlast <= ad_w;
        m_ad <= m_ad + 32'h1;
      end
    end
  end
endmodule

// ==== verilog/pti_bus_if.sv ====
// host bus target/master interface with write-data fifo
//
// Behaviour
// - claim reads only on matching io/mem base
// - devsel driven two clocks after address
// - read data with trdy, then release
// - read burst: stop with trdy until frame
// - claim writes when upper 24 bits match
// - write: irdy sampled, trdy, latch, release
// - write burst: one word, stop until frame
// - request, then frame per grant timing
// - no devsel in eight clocks: master abort
// - master read: irdy after frame, latch data
// - master write: next word after each transfer
// - burst end: frame high, then irdy high
// - master never inserts wait states
// - latency countdown ends burst after grant loss
// - interrupt pin with write-one-clear status
// - mask and global enable gate the pin
// - byte order bit swaps data lanes
// - wide request sampled at reset release
// - optional dual address cycle as master
// - locked config fields need both mode bits
`timescale 1ns/1ps

module pti_fifo #(
  parameter int W = 32,
  parameter int D = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  output logic [$clog2(D):0] count
);
  localparam int AW = $clog2(D);
  // pointers wrap naturally, so depth must be a power of two
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic full;
    logic empty;
  } pti_fifo_st_t;
  pti_fifo_st_t st_r;
  pti_fifo_st_t st_nxt;
  logic [W-1:0] mem [D];
  logic push;
  logic pop;

  assign push = in_valid && !st_r.full;
  assign pop = out_ready && !st_r.empty;
  assign in_ready = !st_r.full;
  assign out_valid = !st_r.empty;
  assign out_data = mem[st_r.rp];
  assign count = st_r.cnt;

  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.wp = st_r.wp + 1'b1;
    end
    if (pop) begin
      st_nxt.rp = st_r.rp + 1'b1;
    end
    st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    st_nxt.full = st_nxt.cnt == (AW+1)'(D);
    st_nxt.empty = st_nxt.cnt == '0;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r <= '0;
      st_r.empty <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[st_r.wp] <= in_data;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////

module pti_bus_if #(
  parameter logic [7:0] CFG0_VALUE = 8'h00,
  parameter logic [15:0] PMC_VALUE = 16'h0000,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [31:0] ad_i,
  output logic [31:0] ad_o,
  output logic ad_oe_n,
  input wire logic [3:0] cbe_i,
  output logic [3:0] cbe_o,
  output logic cbe_oe_n,
  input wire pti_pkg::pti_ctl_t ctl_i,
  output pti_pkg::pti_ctl_t ctl_o,
  output pti_pkg::pti_ctl_t ctl_oe_n,
  output logic bus_request_n,
  input wire logic bus_grant_n,
  input wire logic wide_request_n,
  output logic interrupt_pin_o,
  output logic interrupt_pin_oe_n,
  input wire logic [23:0] io_base_range,
  input wire logic [23:0] mem_base_range,
  input wire logic [7:0] irq_src,
  input wire logic tbi_mode_pin,
  input wire logic mreq_valid,
  input wire pti_pkg::pti_mreq_t mreq,
  output logic mreq_ready,
  output logic mdone,
  output logic mabort,
  output logic [31:0] rdata,
  output logic rdata_valid,
  input wire logic wdata_valid,
  input wire logic [31:0] wdata,
  output logic wdata_ready
);
  pti_pkg::pti_state_t st_r;
  pti_pkg::pti_state_t st_nxt;
  logic fifo_pop;
  logic fifo_rdy;
  logic [31:0] fifo_data;
  logic [$clog2(FIFO_DEPTH):0] fifo_count;

  // in_ready of the fifo is a flop inside it
  pti_fifo #(.W(32), .D(FIFO_DEPTH)) u_wfifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_valid(wdata_valid),
    .in_ready(fifo_rdy),
    .in_data(wdata),
    .out_valid(),
    .out_ready(fifo_pop),
    .out_data(fifo_data),
    .count(fifo_count)
  );

  function automatic logic [31:0] swap32(input logic [31:0] d, input logic en);
    swap32 = en ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
  endfunction

  function automatic logic [7:0] rd_byte(input pti_pkg::pti_state_t s, input logic [7:0] o);
    rd_byte = 8'h00;
    if (o < pti_pkg::OFF_STA_END) begin
      rd_byte = s.sta[8*o[2:0] +: 8];
    end
    case (o)
      pti_pkg::OFF_IMR_LO: rd_byte = s.interrupt_mask_register[7:0];
      pti_pkg::OFF_IMR_HI: rd_byte = s.interrupt_mask_register[15:8];
      pti_pkg::OFF_ISR_LO: rd_byte = s.interrupt_status_register[7:0];
      pti_pkg::OFF_ISR_HI: rd_byte = s.interrupt_status_register[15:8];
      pti_pkg::OFF_EEM: rd_byte = {s.eem, 6'h00};
      pti_pkg::OFF_CFG0: rd_byte = CFG0_VALUE;
      pti_pkg::OFF_CFG1: rd_byte = s.cfg1;
      pti_pkg::OFF_CFG3: rd_byte = s.cfg3;
      pti_pkg::OFF_CFG4: rd_byte = s.cfg4;
      pti_pkg::OFF_CFG5: rd_byte = s.cfg5;
      pti_pkg::OFF_LAT: rd_byte = s.lat;
      pti_pkg::OFF_WIDE: rd_byte = {7'h00, s.bus64};
      pti_pkg::OFF_PHY: rd_byte = {s.tbi_s2, 7'h00};
      pti_pkg::OFF_PMC_LO: rd_byte = PMC_VALUE[7:0];
      pti_pkg::OFF_PMC_HI: rd_byte = PMC_VALUE[15:8];
      pti_pkg::OFF_CCR: rd_byte = s.ccr;
      default: ;
    endcase
  endfunction

  function automatic pti_pkg::pti_state_t wr_byte(input pti_pkg::pti_state_t s, input logic [7:0] o,
                                                  input logic [7:0] v);
    logic unlk;
    unlk = &s.eem;
    wr_byte = s;
    if (o < pti_pkg::OFF_STA_END && unlk) begin
      wr_byte.sta[8*o[2:0] +: 8] = v;
    end
    case (o)
      pti_pkg::OFF_IMR_LO: wr_byte.interrupt_mask_register[7:0] = v;
      pti_pkg::OFF_IMR_HI: wr_byte.interrupt_mask_register[15:8] = v;
      pti_pkg::OFF_ISR_LO: wr_byte.interrupt_status_register[7:0] = s.interrupt_status_register[7:0] & ~v;
      pti_pkg::OFF_ISR_HI: wr_byte.interrupt_status_register[15:8] = s.interrupt_status_register[15:8] & ~v;
      pti_pkg::OFF_EEM: wr_byte.eem = v[pti_pkg::EEM_HI_BIT:pti_pkg::EEM_LO_BIT];
      pti_pkg::OFF_CFG1: if (unlk) wr_byte.cfg1 = (s.cfg1 & ~pti_pkg::CFG1_WMASK) | (v & pti_pkg::CFG1_WMASK);
      pti_pkg::OFF_CFG3: if (unlk) wr_byte.cfg3 = (s.cfg3 & ~pti_pkg::CFG3_WMASK) | (v & pti_pkg::CFG3_WMASK);
      pti_pkg::OFF_CFG4: if (unlk) wr_byte.cfg4 = v & pti_pkg::CFG4_WMASK;
      pti_pkg::OFF_CFG5: if (unlk) wr_byte.cfg5 = v & pti_pkg::CFG5_WMASK;
      pti_pkg::OFF_LAT: wr_byte.lat = v;
      pti_pkg::OFF_CCR: wr_byte.ccr = v & pti_pkg::CCR_WMASK;
      default: ;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic endian;
  logic hit_io;
  logic hit_mem;
  logic claim;
  logic xfer;
  logic dseen;
  logic abort_ev;
  logic [4:0] rem_n;
  logic [31:0] rd_word;
  logic [31:0] wd;
  logic [3:0] be;

  always_comb begin
    st_nxt = st_r;
    fifo_pop = 1'b0;
    abort_ev = 1'b0;
    xfer = 1'b0;
    dseen = 1'b0;
    rem_n = st_r.rem;
    endian = st_r.ccr[pti_pkg::CCR_ENDIAN_BIT];
    hit_io = ad_i[31:8] == io_base_range;
    hit_mem = ad_i[31:8] == mem_base_range;
    claim = ((cbe_i == pti_pkg::CMD_IO_RD || cbe_i == pti_pkg::CMD_IO_WR) && hit_io) ||
            ((cbe_i == pti_pkg::CMD_MEM_RD || cbe_i == pti_pkg::CMD_MEM_WR) && hit_mem);
    for (int i = 0; i < 4; i++) begin
      rd_word[8*i +: 8] = rd_byte(st_r, {st_r.taddr[7:2], 2'(i)});
    end
    wd = swap32(ad_i, endian);
    be = endian ? {cbe_i[0], cbe_i[1], cbe_i[2], cbe_i[3]} : cbe_i;
    st_nxt.mdone = 1'b0;
    st_nxt.mabort = 1'b0;
    st_nxt.rvalid = 1'b0;
    st_nxt.frame_q = ctl_i.frame;
    st_nxt.tbi_s1 = tbi_mode_pin;
    st_nxt.tbi_s2 = st_r.tbi_s1;
    st_nxt.rst_q = 1'b0;
    if (st_r.rst_q) begin
      st_nxt.bus64 = !wide_request_n;
    end
    // a pin driven high for one clock is floated on the next
    st_nxt.ctl_oe_n = st_r.ctl_oe_n | st_r.ctl_o;
    if (!st_r.ctl_oe_n.stop && !st_r.ctl_o.stop && ctl_i.frame) begin
      st_nxt.ctl_o.stop = 1'b1;
    end

    //////////////////////////////////////////////////////////////////////////
    // master side
    if (st_r.lt != 8'h00) begin
      st_nxt.lt = st_r.lt - 8'h01;
    end
    case (st_r.mst)
      pti_pkg::MS_IDLE: begin
        st_nxt.mreq_ready = 1'b1;
        if (mreq_valid && st_r.mreq_ready) begin
          st_nxt.mreq = mreq;
          st_nxt.mreq_ready = 1'b0;
          st_nxt.mst = pti_pkg::MS_FILL;
        end
      end
      pti_pkg::MS_FILL: begin
        // a write burst waits for its whole payload, as no wait state may follow
        if (!st_r.mreq.wr || fifo_count >= st_r.mreq.len) begin
          st_nxt.req_n_o = 1'b0;
          st_nxt.mcnt = 3'h0;
          st_nxt.mst = pti_pkg::MS_REQ;
        end
      end
      pti_pkg::MS_REQ: begin
        if (st_r.mcnt != 3'h7) begin
          st_nxt.mcnt = st_r.mcnt + 3'h1;
        end
        if (!bus_grant_n && st_r.mcnt >= pti_pkg::REQ_TO_FRAME - 3'h1 && st_r.tst == pti_pkg::TS_IDLE &&
            ctl_i.frame && ctl_i.irdy) begin
          st_nxt.ctl_o.frame = 1'b0;
          st_nxt.ctl_oe_n.frame = 1'b0;
          st_nxt.ad_o = st_r.mreq.addr[31:0];
          st_nxt.ad_oe_n = 1'b0;
          st_nxt.dac_pend = st_r.ccr[pti_pkg::CCR_DAC_BIT] && st_r.mreq.addr[63:32] != 32'h0;
          st_nxt.cbe_o = st_nxt.dac_pend ? pti_pkg::CMD_DAC :
                         (st_r.mreq.wr ? pti_pkg::CMD_MEM_WR : pti_pkg::CMD_MEM_RD);
          st_nxt.cbe_oe_n = 1'b0;
          st_nxt.lt = st_r.lat;
          st_nxt.mst = pti_pkg::MS_ADDR;
        end
      end
      pti_pkg::MS_ADDR: begin
        if (st_r.dac_pend) begin
          st_nxt.dac_pend = 1'b0;
          st_nxt.ad_o = st_r.mreq.addr[63:32];
          st_nxt.cbe_o = st_r.mreq.wr ? pti_pkg::CMD_MEM_WR : pti_pkg::CMD_MEM_RD;
        end else begin
          st_nxt.ctl_o.irdy = 1'b0;
          st_nxt.ctl_oe_n.irdy = 1'b0;
          st_nxt.ctl_o.frame = st_r.mreq.len == 5'h01;
          st_nxt.cbe_o = pti_pkg::BE_ALL;
          st_nxt.ad_oe_n = !st_r.mreq.wr;
          st_nxt.ad_o = swap32(fifo_data, endian);
          fifo_pop = st_r.mreq.wr;
          st_nxt.req_n_o = 1'b1;
          st_nxt.rem = st_r.mreq.len;
          st_nxt.dcnt = 4'h0;
          st_nxt.dev_seen = 1'b0;
          st_nxt.mst = pti_pkg::MS_DATA;
        end
      end
      pti_pkg::MS_DATA: begin
        xfer = !ctl_i.trdy && !ctl_i.devsel;
        dseen = st_r.dev_seen || !ctl_i.devsel;
        st_nxt.dev_seen = dseen;
        if (!ctl_i.stop || (!dseen && st_r.dcnt == pti_pkg::DEVSEL_WAIT - 4'h1)) begin
          if (!st_r.ctl_oe_n.frame && !st_r.ctl_o.frame) begin
            st_nxt.ctl_o.frame = 1'b1;
          end
          st_nxt.ad_oe_n = 1'b1;
          st_nxt.cbe_oe_n = 1'b1;
          abort_ev = 1'b1;
          st_nxt.mst = pti_pkg::MS_ABT;
        end else begin
          if (!dseen) begin
            st_nxt.dcnt = st_r.dcnt + 4'h1;
          end
          if (xfer && !st_r.mreq.wr) begin
            st_nxt.rdata = wd;
            st_nxt.rvalid = 1'b1;
          end
          if (xfer && st_r.rem == 5'h01) begin
            st_nxt.ctl_o.irdy = 1'b1;
            st_nxt.ad_oe_n = 1'b1;
            st_nxt.cbe_oe_n = 1'b1;
            st_nxt.mdone = 1'b1;
            st_nxt.mst = pti_pkg::MS_IDLE;
          end else begin
            if (xfer) begin
              rem_n = st_r.rem - 5'h01;
              st_nxt.ad_o = swap32(fifo_data, endian);
              fifo_pop = st_r.mreq.wr;
            end
            if (rem_n > 5'h01 && st_r.lt == 8'h00 && bus_grant_n) begin
              rem_n = 5'h01;
            end
            st_nxt.rem = rem_n;
            if (rem_n == 5'h01 && !st_r.ctl_o.frame) begin
              st_nxt.ctl_o.frame = 1'b1;
            end
          end
        end
      end
      pti_pkg::MS_ABT: begin
        st_nxt.ctl_o.irdy = 1'b1;
        st_nxt.mabort = 1'b1;
        st_nxt.req_n_o = 1'b1;
        st_nxt.mst = pti_pkg::MS_IDLE;
      end
      default: st_nxt.mst = pti_pkg::MS_IDLE;
    endcase

    //////////////////////////////////////////////////////////////////////////
    // target side, only while this end does not own the bus
    case (st_r.tst)
      pti_pkg::TS_IDLE: begin
        if (st_r.frame_q && !ctl_i.frame && claim && st_r.mst != pti_pkg::MS_ADDR &&
            st_r.mst != pti_pkg::MS_DATA && st_r.mst != pti_pkg::MS_ABT) begin
          st_nxt.taddr = ad_i[7:0];
          st_nxt.twr = cbe_i[0];
          st_nxt.tst = pti_pkg::TS_DEC;
        end
      end
      pti_pkg::TS_DEC: begin
        st_nxt.ctl_o.devsel = 1'b0;
        st_nxt.ctl_oe_n.devsel = 1'b0;
        st_nxt.tst = pti_pkg::TS_DEV;
      end
      pti_pkg::TS_DEV: st_nxt.tst = pti_pkg::TS_WT;
      pti_pkg::TS_WT: begin
        if (!st_r.twr) begin
          st_nxt.ad_o = swap32(rd_word, endian);
          st_nxt.ad_oe_n = 1'b0;
          st_nxt.ctl_o.trdy = 1'b0;
          st_nxt.ctl_oe_n.trdy = 1'b0;
          if (!ctl_i.frame) begin
            st_nxt.ctl_o.stop = 1'b0;
            st_nxt.ctl_oe_n.stop = 1'b0;
          end
        end
        st_nxt.tst = pti_pkg::TS_DATA;
      end
      pti_pkg::TS_DATA: begin
        if (!ctl_i.irdy && !st_r.twr) begin
          st_nxt.ctl_o.trdy = 1'b1;
          st_nxt.ctl_o.devsel = 1'b1;
          st_nxt.ad_oe_n = 1'b1;
          st_nxt.tst = pti_pkg::TS_IDLE;
        end else if (!ctl_i.irdy) begin
          st_nxt.ctl_o.trdy = 1'b0;
          st_nxt.ctl_oe_n.trdy = 1'b0;
          if (!ctl_i.frame) begin
            st_nxt.ctl_o.stop = 1'b0;
            st_nxt.ctl_oe_n.stop = 1'b0;
          end
          st_nxt.tst = pti_pkg::TS_WLAT;
        end
      end
      pti_pkg::TS_WLAT: begin
        for (int i = 0; i < 4; i++) begin
          if (!be[i]) begin
            st_nxt = wr_byte(st_nxt, {st_r.taddr[7:2], 2'(i)}, wd[8*i +: 8]);
          end
        end
        st_nxt.ctl_o.trdy = 1'b1;
        st_nxt.ctl_o.devsel = 1'b1;
        st_nxt.tst = pti_pkg::TS_IDLE;
      end
      default: st_nxt.tst = pti_pkg::TS_IDLE;
    endcase

    // events set after the write-one-clear, so a coincident event survives
    st_nxt.interrupt_status_register[7:0] = st_nxt.interrupt_status_register[7:0] | irq_src;
    st_nxt.interrupt_status_register[pti_pkg::ISR_ABORT_BIT] = st_nxt.interrupt_status_register[pti_pkg::ISR_ABORT_BIT] | abort_ev;
    st_nxt.int_oe_n = !(st_nxt.interrupt_mask_register[pti_pkg::IMR_GIE_BIT] &&
                        |(st_nxt.interrupt_status_register[pti_pkg::IMR_GIE_BIT-1:0] & st_nxt.interrupt_mask_register[pti_pkg::IMR_GIE_BIT-1:0]));
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r <= '0;
      st_r.ctl_o <= '1;
      st_r.ctl_oe_n <= '1;
      st_r.ad_oe_n <= 1'b1;
      st_r.cbe_oe_n <= 1'b1;
      st_r.req_n_o <= 1'b1;
      st_r.frame_q <= 1'b1;
      st_r.rst_q <= 1'b1;
      st_r.int_oe_n <= 1'b1;
      st_r.lat <= pti_pkg::LAT_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ad_o = st_r.ad_o;
  assign ad_oe_n = st_r.ad_oe_n;
  assign cbe_o = st_r.cbe_o;
  assign cbe_oe_n = st_r.cbe_oe_n;
  assign ctl_o = st_r.ctl_o;
  assign ctl_oe_n = st_r.ctl_oe_n;
  assign bus_request_n = st_r.req_n_o;
  assign interrupt_pin_o = 1'b0;
  assign interrupt_pin_oe_n = st_r.int_oe_n;
  assign mreq_ready = st_r.mreq_ready;
  assign mdone = st_r.mdone;
  assign mabort = st_r.mabort;
  assign rdata = st_r.rdata;
  assign rdata_valid = st_r.rvalid;
  assign wdata_ready = fifo_rdy;

  ////////////////////////////////////////////////////////////////////////////
  chk_devsel_medium: assert property (@(posedge sys_clk) disable iff (rst)
    st_r.tst == pti_pkg::TS_IDLE && st_nxt.tst == pti_pkg::TS_DEC |-> ##2 !ctl_oe_n.devsel && !ctl_o.devsel)
    else $error("devsel not driven two clocks after claimed address");
  chk_read_trdy: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(ctl_o.devsel) && !st_r.twr |-> ##2 !ctl_o.trdy && !ctl_oe_n.trdy && !ad_oe_n)
    else $error("read data not presented two clocks after devsel");
  chk_trdy_release: assert property (@(posedge sys_clk) disable iff (rst)
    st_r.tst == pti_pkg::TS_DATA && !st_r.twr && !ctl_i.irdy |=> ctl_o.trdy && !ctl_oe_n.trdy ##1 ctl_oe_n.trdy)
    else $error("target ready not released high then floated");
  chk_stop_hold: assert property (@(posedge sys_clk) disable iff (rst)
    !ctl_o.stop && !ctl_oe_n.stop && !ctl_i.frame |=> !ctl_o.stop && !ctl_oe_n.stop)
    else $error("stop dropped while frame still asserted");
  chk_write_latch: assert property (@(posedge sys_clk) disable iff (rst)
    st_r.tst == pti_pkg::TS_DATA && st_r.twr && !ctl_i.irdy |=> !ctl_o.trdy ##1 ctl_o.trdy ##1 ctl_oe_n.trdy)
    else $error("write handshake not trdy, release, float");
  chk_grant_frame: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(bus_request_n) ##1 (!bus_grant_n && ctl_i.frame && ctl_i.irdy && st_r.tst == pti_pkg::TS_IDLE)
    |=> !ctl_o.frame && !ctl_oe_n.frame && !ad_oe_n)
    else $error("frame not started two clocks after request");
  chk_abort_seq: assert property (@(posedge sys_clk) disable iff (rst)
    st_r.mst == pti_pkg::MS_ABT |-> ##1 (ctl_o.irdy && !ctl_oe_n.irdy && ctl_oe_n.frame) ##1 ctl_oe_n.irdy)
    else $error("master abort release order wrong");
  chk_devsel_wait: assert property (@(posedge sys_clk) disable iff (rst)
    st_r.mst == pti_pkg::MS_DATA |-> st_r.dcnt < pti_pkg::DEVSEL_WAIT)
    else $error("waited past devsel limit");
  chk_no_wait: assert property (@(posedge sys_clk) disable iff (rst)
    st_r.mst == pti_pkg::MS_DATA |-> !ctl_o.irdy && !ctl_oe_n.irdy)
    else $error("initiator ready deasserted inside data phase");
  chk_int_gate: assert property (@(posedge sys_clk) disable iff (rst)
    !st_r.interrupt_mask_register[pti_pkg::IMR_GIE_BIT] |-> interrupt_pin_oe_n)
    else $error("interrupt pin pulled with global enable clear");
  chk_eem_lock: assert property (@(posedge sys_clk) disable iff (rst)
    st_r.eem != 2'h3 |=> $stable(st_r.sta) && $stable(st_r.cfg4) && $stable(st_r.cfg5))
    else $error("locked configuration field changed");
endmodule

// ==== verilog/pti_pkg.sv ====
// package: constants, pin groups and state record of the host bus interface
package pti_pkg;
  // bus commands
  localparam logic [3:0] CMD_IO_RD = 4'h2;
  localparam logic [3:0] CMD_IO_WR = 4'h3;
  localparam logic [3:0] CMD_MEM_RD = 4'h6;
  localparam logic [3:0] CMD_MEM_WR = 4'h7;
  localparam logic [3:0] CMD_DAC = 4'hD;
  localparam logic [3:0] BE_ALL = 4'h0;
  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets inside the claimed window
  localparam logic [7:0] OFF_STA_END = 8'h06;
  localparam logic [7:0] OFF_IMR_LO = 8'h3C;
  localparam logic [7:0] OFF_IMR_HI = 8'h3D;
  localparam logic [7:0] OFF_ISR_LO = 8'h3E;
  localparam logic [7:0] OFF_ISR_HI = 8'h3F;
  localparam logic [7:0] OFF_EEM = 8'h50;
  localparam logic [7:0] OFF_CFG0 = 8'h51;
  localparam logic [7:0] OFF_CFG1 = 8'h52;
  localparam logic [7:0] OFF_CFG3 = 8'h54;
  localparam logic [7:0] OFF_CFG4 = 8'h55;
  localparam logic [7:0] OFF_CFG5 = 8'h56;
  localparam logic [7:0] OFF_LAT = 8'h5C;
  localparam logic [7:0] OFF_WIDE = 8'h5D;
  localparam logic [7:0] OFF_PHY = 8'h6C;
  localparam logic [7:0] OFF_PMC_LO = 8'hDE;
  localparam logic [7:0] OFF_PMC_HI = 8'hDF;
  localparam logic [7:0] OFF_CCR = 8'hE1;
  ////////////////////////////////////////////////////////////////////////////
  // field positions and write masks
  localparam int EEM_HI_BIT = 7;
  localparam int EEM_LO_BIT = 6;
  localparam int CCR_ENDIAN_BIT = 1;
  localparam int CCR_DAC_BIT = 4;
  localparam int IMR_GIE_BIT = 15;
  localparam int PHY_TBI_BIT = 7;
  localparam int ISR_ABORT_BIT = 8;
  localparam logic [7:0] EEM_WMASK = 8'hC0;
  localparam logic [7:0] CFG1_WMASK = 8'hF3;
  localparam logic [7:0] CFG3_WMASK = 8'h30;
  localparam logic [7:0] CFG4_WMASK = 8'h94;
  localparam logic [7:0] CFG5_WMASK = 8'h03;
  localparam logic [7:0] CCR_WMASK = 8'h12;
  localparam logic [7:0] LAT_RST = 8'h00;
  // timing in bus clocks
  localparam logic [2:0] REQ_TO_FRAME = 3'h2;
  localparam logic [3:0] DEVSEL_WAIT = 4'h8;
  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic frame;
    logic irdy;
    logic trdy;
    logic devsel;
    logic stop;
  } pti_ctl_t;
  typedef struct packed {
    logic wr;
    logic [63:0] addr;
    logic [4:0] len;
  } pti_mreq_t;
  typedef enum logic [2:0] {TS_IDLE, TS_DEC, TS_DEV, TS_WT, TS_DATA, TS_WLAT} pti_tstate_t;
  typedef enum logic [2:0] {MS_IDLE, MS_FILL, MS_REQ, MS_ADDR, MS_DATA, MS_ABT} pti_mstate_t;
  typedef struct packed {
    pti_tstate_t tst;
    pti_mstate_t mst;
    pti_ctl_t ctl_o;
    pti_ctl_t ctl_oe_n;
    logic [31:0] ad_o;
    logic ad_oe_n;
    logic [3:0] cbe_o;
    logic cbe_oe_n;
    logic req_n_o;
    logic frame_q;
    logic [7:0] taddr;
    logic twr;
    pti_mreq_t mreq;
    logic dac_pend;
    logic [2:0] mcnt;
    logic [4:0] rem;
    logic [3:0] dcnt;
    logic dev_seen;
    logic [7:0] lt;
    logic mreq_ready;
    logic mdone;
    logic mabort;
    logic [31:0] rdata;
    logic rvalid;
    logic [47:0] sta;
    logic [1:0] eem;
    logic [7:0] cfg1;
    logic [7:0] cfg3;
    logic [7:0] cfg4;
    logic [7:0] cfg5;
    logic [7:0] ccr;
    logic [7:0] lat;
    logic [15:0] interrupt_mask_register;
    logic [15:0] interrupt_status_register;
    logic bus64;
    logic rst_q;
    logic tbi_s1;
    logic tbi_s2;
    logic int_oe_n;
  } pti_state_t;
endpackage
